/* core/ide_power_on_strap_config.sv */
// power-on strap capture and ide default configuration registers
`timescale 1ns/100ps
`default_nettype none
`include "ide_strap_cfg.svh"

// Behaviour
// - straps from socket A or shared lines
// - capture straps at reset if pin permits
// - captured bits preload primary timing control defaults
// - strap0 high: take bits, compatible ranges, space on
// - strap0 low: clear bits, base decoding, space off
// - bit0 write selects decode, space untouched
// - bit1 gates primary data/command registers
// - bit2 gates primary control/status register
// - bit3 gates all secondary registers
// - range enables reset to strap or zero
// - bits six and five pick primary mode
// - drive1 shares timing only with bit4
// - bit4 picks drive1 programmable or mode0 timing
// - bit7 sets primary buffering default
// - strap0 low: upper bits configure nothing
// - bits7-4 read-only captured, 3-0 read/write
// - secondary defaults mode0, buffering off
// - primary buffering bits default to bit7
// - no hardware config: setup default 11
module ide_power_on_strap_config (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst,
  // strap pins
  input  wire logic [7:0]             socket_a_data_lines,
  input  wire logic [7:0]             shared_card_data_lines,
  input  wire logic                   four_socket_mode,
  input  wire logic                   hw_cfg_pin_enable,
  // configuration space access
  input  wire ide_strap_pkg::cfg_req_t cfg_req,
  output logic [7:0]                  cfg_rdata,
  output logic                        cfg_rvalid,
  // decode controls
  output logic                        compat_decode,
  output logic                        io_space_enable,
  output logic                        pri_cmd_decode_en,
  output logic                        pri_cs_decode_en,
  output logic                        sec_decode_en,
  // timing and buffering controls
  output ide_strap_pkg::timing_t      primary_timing_control,
  output ide_strap_pkg::timing_t      secondary_timing_control,
  output logic [7:0]                  ide_buffering_control,
  output logic                        config_ready
);
  import ide_strap_pkg::*;

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic [7:0]  strap_meta;        // first synchroniser stage
  logic [7:0]  strap_sync;        // second synchroniser stage
  logic        pin_meta;          // enable pin first stage
  logic        pin_sync;          // enable pin second stage
  phase_t      phase;             // capture phase
  strap_cfg_t  cfg;               // strap configuration register
  strap_cfg_t  next_cfg;          // value loaded at capture
  timing_t     next_ptim;         // primary timing preload
  logic [7:0]  next_buf;          // buffering preload
  logic        capture;           // capture edge
  logic        run_wr;            // accepted write

  // ----------------------------------------------------------------
  // timing preload per mode
  // ----------------------------------------------------------------
  function automatic timing_t mode_timing(input logic [1:0] mode);
    timing_t t;
    t = '0;
    // pick the per-mode field values
    case (mode)
      2'h0: begin
        t.setup = `M0_SETUP;
        t.pulse = `M0_PULSE;
        t.cycle = `M0_CYCLE;
      end
      2'h1: begin
        t.setup = `M1_SETUP;
        t.pulse = `M1_PULSE;
        t.cycle = `M1_CYCLE;
      end
      2'h2: begin
        t.setup = `M2_SETUP;
        t.pulse = `M2_PULSE;
        t.cycle = `M2_CYCLE;
      end
      default: begin
        t.setup = `M3_SETUP;
        t.pulse = `M3_PULSE;
        t.cycle = `M3_CYCLE;
      end
    endcase
    return t;
  endfunction : mode_timing

  // ----------------------------------------------------------------
  // strap synchronisers
  // ----------------------------------------------------------------
  // no reset here: straps must be sampled while rst is high
  always_ff @(posedge clk) begin
    strap_meta <= four_socket_mode ? shared_card_data_lines
                                   : socket_a_data_lines;
    strap_sync <= strap_meta;
    pin_meta   <= hw_cfg_pin_enable;
    pin_sync   <= pin_meta;
  end

  // ----------------------------------------------------------------
  // capture value
  // ----------------------------------------------------------------
  // the feature needs the global pin and strap0 both high
  always_comb begin
    next_cfg = '0;
    // pin disables the feature: nothing is latched
    if (pin_sync && strap_sync[`CFG_HW_BIT]) begin
      next_cfg = strap_cfg_t'(strap_sync);
    end else begin
      next_cfg = '0;
    end
  end

  // primary timing preload from captured bits
  always_comb begin
    next_ptim = mode_timing(2'h0);
    next_ptim.drv0_en = 1'b1;
    // hardware configuration picks mode and drive 1 timing
    if (next_cfg.hw_cfg) begin
      next_ptim = mode_timing(next_cfg.timing_mode);
      next_ptim.drv0_en = 1'b1;
      next_ptim.drv1_en = next_cfg.drv1_timing;
    end
  end

  // primary buffering preload, secondary half stays off
  always_comb begin
    next_buf = `RST_BUFFERING;
    // bit 7 feeds the four primary bits only
    if (next_cfg.hw_cfg && next_cfg.buf_default) begin
      next_buf = `BUF_PRI_MASK;
    end
  end

  assign capture = (phase == PH_WAIT);
  assign run_wr  = cfg_req.wr && (phase == PH_RUN);

  // ----------------------------------------------------------------
  // capture phase
  // ----------------------------------------------------------------
  // first edge after release takes the straps, then runs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase <= PH_WAIT;
    end else begin
      // leave the wait phase exactly once
      case (phase)
        PH_WAIT: phase <= PH_RUN;
        PH_RUN:  phase <= PH_RUN;
        default: phase <= PH_WAIT;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // strap configuration register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg <= strap_cfg_t'(`RST_STRAP_CFG);
    end else if (capture) begin
      cfg <= next_cfg;
    end else if (run_wr && cfg_req.addr == `OFS_STRAP_CFG) begin
      // upper nibble keeps the captured straps
      cfg <= strap_cfg_t'((cfg & ~`CFG_RW_MASK)
             | (cfg_req.wdata & `CFG_RW_MASK));
    end
  end

  // io space default follows the capture, never a write
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      io_space_enable <= 1'b0;
    end else if (capture) begin
      io_space_enable <= next_cfg.hw_cfg;
    end
  end

  // ----------------------------------------------------------------
  // buffering control register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ide_buffering_control <= `RST_BUFFERING;
    end else if (capture) begin
      ide_buffering_control <= next_buf;
    end else if (run_wr && cfg_req.addr == `OFS_BUFFERING) begin
      ide_buffering_control <= cfg_req.wdata;
    end
  end

  // ----------------------------------------------------------------
  // primary timing control register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      primary_timing_control <= timing_t'(`RST_PTIM);
    end else if (capture) begin
      primary_timing_control <= next_ptim;
    end else if (run_wr && cfg_req.addr == `OFS_PTIM_LO) begin
      primary_timing_control[7:0] <= cfg_req.wdata & 8'(`TIM_RW_MASK);
    end else if (run_wr && cfg_req.addr == `OFS_PTIM_HI) begin
      primary_timing_control[15:8] <= cfg_req.wdata
                                      & 8'(`TIM_RW_MASK >> 8);
    end
  end

  // ----------------------------------------------------------------
  // secondary timing control register
  // ----------------------------------------------------------------
  // straps never touch it: mode 0 after every reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      secondary_timing_control <= timing_t'(`RST_STIM);
    end else if (run_wr && cfg_req.addr == `OFS_STIM_LO) begin
      secondary_timing_control[7:0] <= cfg_req.wdata & 8'(`TIM_RW_MASK);
    end else if (run_wr && cfg_req.addr == `OFS_STIM_HI) begin
      secondary_timing_control[15:8] <= cfg_req.wdata
                                        & 8'(`TIM_RW_MASK >> 8);
    end
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  // unmapped offsets answer zero, one cycle after the strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_rdata  <= 8'h00;
      cfg_rvalid <= 1'b0;
    end else begin
      cfg_rvalid <= cfg_req.rd;
      // select the addressed byte
      case (cfg_req.addr)
        `OFS_STRAP_CFG: cfg_rdata <= cfg;
        `OFS_BUFFERING: cfg_rdata <= ide_buffering_control;
        `OFS_PTIM_LO:   cfg_rdata <= primary_timing_control[7:0];
        `OFS_PTIM_HI:   cfg_rdata <= primary_timing_control[15:8];
        `OFS_STIM_LO:   cfg_rdata <= secondary_timing_control[7:0];
        `OFS_STIM_HI:   cfg_rdata <= secondary_timing_control[15:8];
        default:        cfg_rdata <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // decode enables
  // ----------------------------------------------------------------
  // registered copies so the decoders see flops
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      compat_decode     <= 1'b0;
      pri_cmd_decode_en <= 1'b0;
      pri_cs_decode_en  <= 1'b0;
      sec_decode_en     <= 1'b0;
      config_ready      <= 1'b0;
    end else begin
      compat_decode     <= cfg.hw_cfg;
      pri_cmd_decode_en <= cfg.pri_cmd_en;
      pri_cs_decode_en  <= cfg.pri_cs_en;
      sec_decode_en     <= cfg.sec_en;
      config_ready      <= (phase == PH_RUN);
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // the release edge still samples rst high, so it is no capture edge
  sequence s_capture;
    phase == PH_WAIT && !rst;
  endsequence

  sequence s_cfg_write;
    phase == PH_RUN && cfg_req.wr && cfg_req.addr == `OFS_STRAP_CFG;
  endsequence

  AST_CAPTURE_VALUE: assert property (
    @(posedge clk) disable iff (rst)
    s_capture |=> cfg == $past(next_cfg))
    else $error("capture did not load straps");

  AST_NO_HW_CLEAR: assert property (
    @(posedge clk) disable iff (rst)
    s_capture ##0 !next_cfg.hw_cfg |=> cfg[7:1] == 7'h00
      && !io_space_enable)
    else $error("upper bits not cleared");

  AST_UPPER_RO: assert property (
    @(posedge clk) disable iff (rst)
    phase == PH_RUN ##1 phase == PH_RUN |-> $stable(cfg[7:4]))
    else $error("read-only bits changed");

  AST_LOW_WRITE: assert property (
    @(posedge clk) disable iff (rst)
    s_cfg_write |=> cfg[3:0] == $past(cfg_req.wdata[3:0])
      ##1 compat_decode == $past(cfg.hw_cfg))
    else $error("low nibble write lost");

  AST_SPACE_HELD: assert property (
    @(posedge clk) disable iff (rst)
    phase == PH_RUN |=> $stable(io_space_enable))
    else $error("io space changed by write");

  AST_PTIM_PRELOAD: assert property (
    @(posedge clk) disable iff (rst)
    s_capture |=> primary_timing_control.drv1_en
      == $past(next_cfg.hw_cfg && next_cfg.drv1_timing))
    else $error("drive 1 timing preload wrong");

  AST_SETUP_DEF: assert property (
    @(posedge clk) disable iff (rst)
    s_capture ##0 !next_cfg.hw_cfg |=>
      primary_timing_control.setup == 2'h3)
    else $error("setup default not mode 0");

  AST_BUF_PRELOAD: assert property (
    @(posedge clk) disable iff (rst)
    s_capture |=> ide_buffering_control
      == {4'h0, {4{$past(next_cfg.hw_cfg && next_cfg.buf_default)}}})
    else $error("buffering preload wrong");

  AST_SEC_DEF: assert property (
    @(posedge clk) disable iff (rst)
    s_capture |=> secondary_timing_control == timing_t'(`RST_STIM))
    else $error("secondary timing default wrong");

  AST_RANGE_EN: assert property (
    @(posedge clk) disable iff (rst)
    s_cfg_write |=> ##1 sec_decode_en == $past(cfg_req.wdata[3], 2))
    else $error("secondary enable not applied");

  AST_READBACK: assert property (
    @(posedge clk) disable iff (rst)
    cfg_req.rd && cfg_req.addr == `OFS_STRAP_CFG |=>
      cfg_rvalid && cfg_rdata == $past(cfg))
    else $error("readback mismatch");

endmodule : ide_power_on_strap_config
`default_nettype wire

/* core/ide_strap_cfg.svh */
// constants of the power-on ide strap configuration block
`ifndef IDE_STRAP_CFG_SVH
`define IDE_STRAP_CFG_SVH

// ----------------------------------------------------------------
// configuration space byte offsets
// ----------------------------------------------------------------
`define OFS_BUFFERING    8'h40
`define OFS_STRAP_CFG    8'h44
`define OFS_PTIM_LO      8'h48
`define OFS_PTIM_HI      8'h49
`define OFS_STIM_LO      8'h4A
`define OFS_STIM_HI      8'h4B

// ----------------------------------------------------------------
// field positions and masks
// ----------------------------------------------------------------
`define CFG_RW_MASK      8'h0F
`define CFG_HW_BIT       0
`define CFG_BUF_BIT      7
`define BUF_PRI_MASK     8'h0F
`define TIM_RW_MASK      16'hF77F

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_STRAP_CFG    8'h00
`define RST_BUFFERING    8'h00
`define RST_PTIM         16'h3659
`define RST_STIM         16'h3658

// ----------------------------------------------------------------
// timing fields per mode: setup, pulse width, cycle time
// ----------------------------------------------------------------
`define M0_SETUP         2'h3
`define M0_PULSE         3'h6
`define M0_CYCLE         5'h16
`define M1_SETUP         2'h2
`define M1_PULSE         3'h4
`define M1_CYCLE         5'h0E
`define M2_SETUP         2'h1
`define M2_PULSE         3'h3
`define M2_CYCLE         5'h0A
`define M3_SETUP         2'h1
`define M3_PULSE         3'h2
`define M3_CYCLE         5'h08

`endif

/* core/ide_strap_pkg.sv */
// types of the power-on ide strap configuration block
package ide_strap_pkg;

  // ----------------------------------------------------------------
  // strap configuration byte layout
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       buf_default;   // primary buffering default
    logic [1:0] timing_mode;   // primary timing mode
    logic       drv1_timing;   // drive 1 programmable timing
    logic       sec_en;        // secondary ranges enable
    logic       pri_cs_en;     // primary control/status enable
    logic       pri_cmd_en;    // primary data/command enable
    logic       hw_cfg;        // hardware configuration / decode select
  } strap_cfg_t;

  // ----------------------------------------------------------------
  // timing control word layout
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       iordy1_ovr;    // drive 1 ready override
    logic       iordy0_ovr;    // drive 0 ready override
    logic [1:0] setup;         // address/data setup
    logic       rsv11;         // reserved, reads zero
    logic [2:0] pulse;         // strobe pulse width
    logic       rsv7;          // reserved, reads zero
    logic [4:0] cycle;         // overall cycle time
    logic       drv1_en;       // drive 1 enhanced timing
    logic       drv0_en;       // drive 0 enhanced timing
  } timing_t;

  // ----------------------------------------------------------------
  // configuration access request
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       wr;            // write strobe, one cycle
    logic       rd;            // read strobe, one cycle
    logic [7:0] addr;          // byte offset
    logic [7:0] wdata;         // write byte
  } cfg_req_t;

  // ----------------------------------------------------------------
  // capture phase
  // ----------------------------------------------------------------
  typedef enum logic {
    PH_WAIT,
    PH_RUN
  } phase_t;

endpackage : ide_strap_pkg

/* sim/strap_pull_model.sv */
// board strap pulls and later card traffic on the card data lines
`timescale 1ns/100ps
`default_nettype none
module strap_pull_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // strap setting of the board
  input  wire logic [7:0] strap,
  input  wire logic       four_socket_mode,
  // card data lines
  output var  logic [7:0] socket_a_data_lines,
  output var  logic [7:0] shared_card_data_lines
);
  logic [2:0] hold;  // edges since reset release

  // ----------------------------------------------------------------
  // edge counter after release
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (rst) begin
      hold <= 3'h0;
    end else if (hold != 3'h7) begin
      hold <= hold + 3'h1;
    end
  end

  // ----------------------------------------------------------------
  // line levels: pulls around reset end, toggling traffic after
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (rst || hold < 3'h4) begin  // levels stable through reset end
      // unselected lines carry the inverse so a wrong source shows
      socket_a_data_lines    <= four_socket_mode ? ~strap : strap;
      shared_card_data_lines <= four_socket_mode ? strap : ~strap;
    end else begin  // cards own the lines now
      socket_a_data_lines    <= ~socket_a_data_lines;
      shared_card_data_lines <= ~shared_card_data_lines;
    end
  end
endmodule : strap_pull_model
`default_nettype wire

/* sim/tb_top.sv */
// self-checking bench of the power-on strap configuration block
`timescale 1ns/100ps
`default_nettype none
`include "ide_strap_cfg.svh"
`define CHK(got, exp) check(16'(got), 16'(exp))
module tb_top;
  import ide_strap_pkg::*;
  logic        clk, rst, four_socket_mode, hw_cfg_pin_enable;
  logic [7:0]  strap, socket_a_data_lines, shared_card_data_lines;
  logic [7:0]  cfg_rdata, ide_buffering_control, rd_data;
  logic        cfg_rvalid, compat_decode, io_space_enable, config_ready;
  logic        pri_cmd_decode_en, pri_cs_decode_en, sec_decode_en;
  cfg_req_t    cfg_req;
  timing_t     primary_timing_control, secondary_timing_control;
  int          n_fail, comparisons, cycles;
  logic [31:0] seed;

  // ----------------------------------------------------------------
  // design, strap model
  // ----------------------------------------------------------------
  ide_power_on_strap_config i_dut (.clk, .rst, .socket_a_data_lines,
    .shared_card_data_lines, .four_socket_mode, .hw_cfg_pin_enable, .cfg_req,
    .cfg_rdata, .cfg_rvalid, .compat_decode, .io_space_enable, .pri_cmd_decode_en,
    .pri_cs_decode_en, .sec_decode_en, .primary_timing_control,
    .secondary_timing_control, .ide_buffering_control, .config_ready);
  strap_pull_model i_pull (.clk, .rst, .strap, .four_socket_mode,
    .socket_a_data_lines, .shared_card_data_lines);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rand32();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rand32

  // expected primary timing word after capture
  function automatic logic [15:0] exp_ptim(logic [7:0] s, logic p);
    timing_t t;
    t = 16'h3659;
    if (p && s[0]) begin
      case (s[6:5])
        2'h0: {t.setup, t.pulse, t.cycle} = {`M0_SETUP, `M0_PULSE, `M0_CYCLE};
        2'h1: {t.setup, t.pulse, t.cycle} = {`M1_SETUP, `M1_PULSE, `M1_CYCLE};
        2'h2: {t.setup, t.pulse, t.cycle} = {`M2_SETUP, `M2_PULSE, `M2_CYCLE};
        default: {t.setup, t.pulse, t.cycle} = {`M3_SETUP, `M3_PULSE, `M3_CYCLE};
      endcase
      t.drv1_en = s[4];
    end
    return t;
  endfunction : exp_ptim

  task automatic check(logic [15:0] got, logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // one write, request held for exactly one edge
  task automatic cfg_wr(logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    cfg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    cfg_req <= '0;
  endtask : cfg_wr

  // one read, answer taken in its single valid cycle
  task automatic cfg_rd(logic [7:0] a);
    @(posedge clk);
    cfg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    cfg_req <= '0;
    #1;
    `CHK(cfg_rvalid, 1'b1);
    rd_data = cfg_rdata;
  endtask : cfg_rd

  task automatic results();
    $display("counts: fail=%0d comparisons=%0d", n_fail, comparisons);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results

  // ----------------------------------------------------------------
  // clock and hang guard
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin  // far beyond the planned run
      n_fail++;
      results();
    end
  end

  // ----------------------------------------------------------------
  // main sequence: one reset per case, corners first
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] r;
    logic [7:0]  s, w, ec;
    logic [15:0] ep;
    logic [7:0]  ofs [7];
    logic [7:0]  ex [7];
    logic        p;
    rst = 1'b1;
    cfg_req = '0;
    strap = 8'h00;
    four_socket_mode = 1'b0;
    hw_cfg_pin_enable = 1'b0;
    seed = 32'd69;
    for (int i = 0; i < 14; i++) begin
      r = rand32();
      p = 1'b1;
      if (i < 4) begin  // each timing mode with configuration on
        s = {r[7], i[1:0], r[4:1], 1'b1};
      end else if (i == 4) begin  // strap 0 low, upper straps high
        s = 8'hFE;
      end else if (i == 5) begin  // feature pin low
        s = 8'hFF;
        p = 1'b0;
      end else begin
        s = r[7:0];
        p = r[8] | r[9];
      end
      @(posedge clk);
      rst <= 1'b1;
      strap <= s;
      hw_cfg_pin_enable <= p;
      four_socket_mode <= (i < 2) ? i[0] : r[10];  // both strap sources surely used
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      cfg_req <= '{wr: 1'b1, rd: 1'b0, addr: 8'h44, wdata: ~s};  // capture cycle
      @(posedge clk);
      cfg_req <= '0;
      repeat (2) @(posedge clk);
      #1;
      ec = (p && s[0]) ? s : 8'h00;
      ep = exp_ptim(s, p);
      `CHK(config_ready, 1'b1);
      `CHK({io_space_enable, compat_decode}, {2{ec[0]}});
      `CHK({sec_decode_en, pri_cs_decode_en, pri_cmd_decode_en}, ec[3:1]);
      `CHK(primary_timing_control, ep);
      `CHK(secondary_timing_control, 16'h3658);
      `CHK(ide_buffering_control, {4'h0, {4{ec[7]}}});
      ofs = '{8'h44, 8'h40, 8'h48, 8'h49, 8'h4A, 8'h4B, 8'h50};
      ex = '{ec, {4'h0, {4{ec[7]}}}, ep[7:0], ep[15:8], 8'h58, 8'h36, 8'h00};
      for (int k = 0; k < 7; k++) begin
        cfg_rd(ofs[k]);
        `CHK(rd_data, ex[k]);
      end
      w = 8'(rand32());
      cfg_wr(8'h44, w);
      cfg_rd(8'h44);
      `CHK(rd_data, {ec[7:4], w[3:0]});
      `CHK({io_space_enable, compat_decode}, {ec[0], w[0]});
      `CHK({sec_decode_en, pri_cs_decode_en, pri_cmd_decode_en}, w[3:1]);
    end
    results();
  end
endmodule : tb_top
`default_nettype wire
